//--- src/sac_defs.svh
// timing counts and reset values for the step attenuator control port
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH

`define SAC_CLK_PERIOD_NS 100
`define SAC_ATTEN_W 7
`define SAC_WORD_W 8
`define SAC_ATTEN_MAX 7'h7F
`define SAC_SCLK_HALF_NS 20
`define SAC_STB_DELAY_NS 10
`define SAC_STB_WIDTH_NS 10
`define SAC_MODE_SETUP_NS 100
`define SAC_CEIL_CYC(ns) (((ns) + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)
`define SAC_SCLK_HALF_CYC 4
`define SAC_STB_DELAY_CYC `SAC_CEIL_CYC(`SAC_STB_DELAY_NS)
`define SAC_STB_WIDTH_CYC `SAC_CEIL_CYC(`SAC_STB_WIDTH_NS)
`define SAC_MODE_SETUP_CYC `SAC_CEIL_CYC(`SAC_MODE_SETUP_NS)

`endif

//--- src/sac_pkg.sv
// state type of the host end of the step attenuator control port
`default_nettype none
package sac_pkg;
    typedef enum logic [2:0] {
        SAC_IDLE = 3'h0,
        SAC_SHIFT_LO = 3'h1,
        SAC_SHIFT_HI = 3'h3,
        SAC_STB_WAIT = 3'h2,
        SAC_STB_HIGH = 3'h6,
        SAC_PAR_WAIT = 3'h7,
        SAC_PAR_LOW = 3'h5,
        SAC_PAR_HIGH = 3'h4
    } sac_host_state_t;
endpackage : sac_pkg
`default_nettype wire

//--- src/sac_if.sv
// pin bundle between attenuator control port and host
`timescale 1ns/1ps
`default_nettype none
interface sac_if;
    logic serial_sel;
    logic latch_strobe;
    logic sclk;
    logic sdata;
    logic [6:0] par_atten;
    modport dev (input serial_sel, latch_strobe, sclk, sdata, par_atten);
    modport host (output serial_sel, latch_strobe, sclk, sdata, par_atten);
endinterface : sac_if
`default_nettype wire

//--- src/sac_device.sv
// attenuator control port: serial and parallel loading of attenuation
//
// Functional notes
// R1: serial select high means serial, else parallel
// R2: eight bit word, top bit ignored
// R3: host shifts least significant bit first
// R4: host grounds parallel inputs in serial mode
// R5: binary weights, 16 dB down to quarter dB
// R6: serial word commits on strobe rising edge
// R7: host keeps strobe low while shifting
// R8: attenuation changes only on commit
// R9: host serial clock 25 MHz, 20 ns phases; host uses 1 MHz, 500 ns (5 cycle) phases
// R10: strobe rises 10 ns after last edge; host raises it 500 ns after last sclk fall
// R11: host holds strobe high 10 ns; host holds it high 500 ns
// R12: reset sets maximum attenuation
// R13: parallel with strobe high follows inputs
// R14: host may ground serial pins in parallel
// R15: latched parallel holds while strobe low
// R16: strobe rising edge captures parallel inputs
// R17: parallel bits weighted as serial bits
// R18: host waits 100 ns before parallel load
// R19: data sampled on serial clock rising edge
// R20: commit uses last eight bits, first is LSB
`timescale 1ns/1ps
`default_nettype none
`include "sac_defs.svh"
module sac_device
    import sac_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    sac_if.dev pins,
    output logic [6:0] atten,
    output logic serial_mode
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] sel_s;
        logic [1:0] stb_s;
        logic [1:0] clk_s;
        logic [1:0] dat_s;
        logic [13:0] par_s;
        logic stb_d;
        logic clk_d;
        logic [7:0] shift;
        logic [6:0] atten;
        logic serial_mode;
    } sac_dev_st_t;

    sac_dev_st_t st;
    sac_dev_st_t next_st;

    // rising edge of a synchronised pin against its delayed copy
    function automatic logic rise_seen(input logic now, input logic prev);
        return now && !prev;
    endfunction : rise_seen

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.sel_s = {st.sel_s[0], pins.serial_sel};
        next_st.stb_s = {st.stb_s[0], pins.latch_strobe};
        next_st.clk_s = {st.clk_s[0], pins.sclk};
        next_st.dat_s = {st.dat_s[0], pins.sdata};
        next_st.par_s = {st.par_s[6:0], pins.par_atten};
        next_st.stb_d = st.stb_s[1];
        next_st.clk_d = st.clk_s[1];
        next_st.serial_mode = st.sel_s[1]; // R1
        if (rise_seen(st.clk_s[1], st.clk_d)) begin
            next_st.shift = {st.dat_s[1], st.shift[7:1]}; // R19 R3
        end
        if (st.sel_s[1]) begin
            if (rise_seen(st.stb_s[1], st.stb_d)) begin
                next_st.atten = st.shift[6:0]; // R6 R8 R20 R2 R5
            end
        end else if (st.stb_s[1]) begin
            next_st.atten = st.par_s[13:7]; // R13 R16 R17
        end // R15
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.atten <= `SAC_ATTEN_MAX; // R12
        end else begin
            st <= next_st;
        end
    end

    assign atten = st.atten;
    assign serial_mode = st.serial_mode;
endmodule : sac_device
`default_nettype wire

//--- src/sac_host.sv
// host end: drives serial words or parallel loads into the port
`timescale 1ns/1ps
`default_nettype none
`include "sac_defs.svh"
module sac_host
    import sac_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    sac_if.host pins,
    input wire logic req,
    input wire logic req_serial,
    input wire logic req_direct,
    input wire logic [6:0] req_atten,
    output logic busy
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        sac_host_state_t fsm;
        logic [7:0] cnt;
        logic [3:0] bits;
        logic [7:0] word;
        logic sel;
        logic stb;
        logic sclk;
        logic sdata;
        logic [6:0] par;
        logic direct;
        logic busy;
    } sac_host_st_t;

    sac_host_st_t st;
    sac_host_st_t next_st;

    always_comb begin
        next_st = st;
        if (st.cnt != 8'h00) begin
            next_st.cnt = st.cnt - 8'h01;
        end
        case (st.fsm)
            SAC_IDLE: begin
                next_st.busy = 1'b0;
                if (req) begin
                    next_st.busy = 1'b1;
                    next_st.direct = req_direct;
                    if (req_serial) begin
                        next_st.sel = 1'b1;
                        next_st.par = 7'h00; // R4
                        next_st.stb = 1'b0; // R7
                        next_st.word = {1'b0, req_atten}; // R2
                        next_st.bits = 4'h0;
                        next_st.cnt = 8'(`SAC_SCLK_HALF_CYC);
                        next_st.fsm = SAC_SHIFT_LO;
                    end else begin
                        next_st.sclk = 1'b0; // R14
                        next_st.sdata = 1'b0;
                        next_st.stb = 1'b0;
                        next_st.par = req_atten;
                        next_st.cnt = st.sel ? 8'(`SAC_MODE_SETUP_CYC)
                                             : 8'h01; // R18
                        next_st.sel = 1'b0;
                        next_st.fsm = SAC_PAR_WAIT;
                    end
                end
            end
            SAC_SHIFT_LO: begin
                next_st.sclk = 1'b0;
                next_st.sdata = st.word[0]; // R3
                if (st.cnt == 8'h00) begin
                    next_st.sclk = 1'b1;
                    next_st.word = {1'b0, st.word[7:1]};
                    next_st.bits = st.bits + 4'h1;
                    next_st.cnt = 8'(`SAC_SCLK_HALF_CYC); // R9
                    next_st.fsm = SAC_SHIFT_HI;
                end
            end
            SAC_SHIFT_HI: begin
                if (st.cnt == 8'h00) begin
                    next_st.sclk = 1'b0;
                    next_st.cnt = 8'(`SAC_SCLK_HALF_CYC);
                    next_st.fsm = (st.bits == 4'h8) ? SAC_STB_WAIT
                                                    : SAC_SHIFT_LO;
                end
            end
            SAC_STB_WAIT: begin
                if (st.cnt == 8'h00) begin
                    next_st.stb = 1'b1; // R10
                    next_st.cnt = 8'(`SAC_SCLK_HALF_CYC);
                    next_st.fsm = SAC_STB_HIGH;
                end
            end
            SAC_STB_HIGH: begin
                if (st.cnt == 8'h00) begin
                    next_st.stb = 1'b0; // R11
                    next_st.fsm = SAC_IDLE;
                end
            end
            SAC_PAR_WAIT: begin
                if (st.cnt == 8'h00) begin
                    next_st.stb = st.direct;
                    next_st.cnt = 8'(`SAC_SCLK_HALF_CYC);
                    next_st.fsm = st.direct ? SAC_IDLE : SAC_PAR_LOW;
                end
            end
            SAC_PAR_LOW: begin
                if (st.cnt == 8'h00) begin
                    next_st.stb = 1'b1;
                    next_st.cnt = 8'(`SAC_SCLK_HALF_CYC);
                    next_st.fsm = SAC_PAR_HIGH;
                end
            end
            SAC_PAR_HIGH: begin
                if (st.cnt == 8'h00) begin
                    next_st.stb = 1'b0;
                    next_st.fsm = SAC_IDLE;
                end
            end
            default: next_st.fsm = SAC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pins.serial_sel = st.sel;
    assign pins.latch_strobe = st.stb;
    assign pins.sclk = st.sclk;
    assign pins.sdata = st.sdata;
    assign pins.par_atten = st.par;
    assign busy = st.busy;
endmodule : sac_host
`default_nettype wire

//--- tb/sac_assertions.sv
// assertions on the attenuator control pins and outputs
`timescale 1ns/1ps
`default_nettype none
module sac_assertions (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic serial_sel,
    input wire logic latch_strobe,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic [6:0] par_atten,
    input wire logic [6:0] atten,
    input wire logic serial_mode
);
    logic sclk_q;
    logic [7:0] shreg;
    logic [3:0] stb_age;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    // ----
    // helper logic
    // ----
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_q <= 1'b0;
            shreg <= 8'h00;
            stb_age <= 4'hF;
        end else begin
            sclk_q <= sclk;
            if (sclk && !sclk_q) begin
                shreg <= {sdata, shreg[7:1]};
            end
            if (latch_strobe) begin
                stb_age <= 4'h0;
            end else if (stb_age != 4'hF) begin
                stb_age <= stb_age + 4'h1;
            end
        end
    end
    // ----
    // properties
    // ----
    reset_max_a: assert property (
        $rose(rst_b) |-> atten == 7'h7F && !serial_mode)
        else $error("attenuation not at maximum after reset");
    mode_rise_a: assert property (
        $rose(serial_sel) |-> ##[1:4] serial_mode)
        else $error("serial mode not entered");
    mode_fall_a: assert property (
        $fell(serial_sel) |-> ##[1:4] !serial_mode)
        else $error("parallel mode not entered");
    serial_commit_a: assert property (
        serial_sel && $rose(latch_strobe) |-> ##[2:6] atten == shreg[6:0])
        else $error("serial word not committed");
    direct_follow_a: assert property (
        (!serial_sel && latch_strobe && $stable(par_atten))[*6]
        |-> atten == par_atten)
        else $error("direct parallel value not followed");
    latch_capture_a: assert property (
        !serial_sel && $rose(latch_strobe) |-> ##[2:6] atten == par_atten)
        else $error("latched parallel value not taken");
    change_age_a: assert property (
        $changed(atten) |-> stb_age <= 4'h6)
        else $error("attenuation changed without strobe");
    strobe_low_a: assert property (
        serial_sel && $rose(sclk) |-> !latch_strobe)
        else $error("strobe high while shifting");
    par_ground_a: assert property (
        serial_sel |-> par_atten == 7'h00)
        else $error("parallel inputs not grounded in serial mode");
    serial_quiet_a: assert property (
        !serial_sel |-> !sclk && !sdata)
        else $error("serial pins not grounded in parallel mode");
endmodule : sac_assertions
`default_nettype wire

//--- tb/testbench.sv
// testbench joining host and device ends of the control port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic req = 1'b0;
    logic req_serial = 1'b0;
    logic req_direct = 1'b0;
    logic [6:0] req_atten = 7'h00;
    logic [6:0] atten;
    logic serial_mode;
    logic busy;
    int n_errors = 0;
    int n_checks = 0;
    sac_if sac_if_i ();
    sac_device sac_device_i (.core_clk(core_clk), .rst_b(rst_b),
        .pins(sac_if_i.dev), .atten(atten), .serial_mode(serial_mode));
    sac_host sac_host_i (.core_clk(core_clk), .rst_b(rst_b),
        .pins(sac_if_i.host), .req(req), .req_serial(req_serial),
        .req_direct(req_direct), .req_atten(req_atten), .busy(busy));
    sac_assertions sac_assertions_i (.core_clk(core_clk), .rst_b(rst_b),
        .serial_sel(sac_if_i.serial_sel), .sclk(sac_if_i.sclk),
        .latch_strobe(sac_if_i.latch_strobe), .sdata(sac_if_i.sdata),
        .par_atten(sac_if_i.par_atten), .atten(atten),
        .serial_mode(serial_mode));
    always #50 core_clk = ~core_clk;
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask : tick
    // ----
    // one request through the host, then judge the device
    // ----
    task automatic load(input logic s, input logic d, input logic [6:0] v);
        logic [6:0] old;
        old = atten;
        req = 1'b1;
        req_serial = s;
        req_direct = d;
        req_atten = v;
        tick();
        req = 1'b0;
        check({7'h00, busy}, 8'h01);
        if (!d) begin
            for (int i = 0; i < 300 && !sac_if_i.latch_strobe; i++) tick();
            check({7'h00, sac_if_i.latch_strobe}, 8'h01);
            check({1'b0, atten}, {1'b0, old});
            if (s) begin
                check({1'b0, sac_if_i.par_atten}, 8'h00);
            end else begin
                check({6'h00, sac_if_i.sclk, sac_if_i.sdata}, 8'h00);
            end
        end
        for (int i = 0; i < 300 && busy; i++) tick();
        check({7'h00, busy}, 8'h00);
        repeat (8) tick();
        check({serial_mode, atten}, {s, v});
    endtask : load
    // ----
    // scenarios
    // ----
    task automatic t_reset();
        check({serial_mode, atten}, 8'h7F);
    endtask : t_reset
    task automatic t_serial();
        for (int b = 0; b < 7; b++) load(1'b1, 1'b0, 7'h01 << b);
        load(1'b1, 1'b0, 7'h00);
        load(1'b1, 1'b0, 7'h7F);
    endtask : t_serial
    task automatic t_latched();
        load(1'b0, 1'b0, 7'h55);
        load(1'b0, 1'b0, 7'h2A);
    endtask : t_latched
    task automatic t_direct();
        load(1'b0, 1'b1, 7'h33);
        load(1'b0, 1'b1, 7'h4C);
    endtask : t_direct
    task automatic t_swap();
        load(1'b1, 1'b0, 7'h19);
        load(1'b0, 1'b0, 7'h66);
    endtask : t_swap
    initial begin
        repeat (12) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        tick();
        t_reset();
        t_serial();
        t_latched();
        t_direct();
        t_swap();
        close_out();
    end
    initial begin
        #(6000 * 100);
        n_errors++;
        close_out();
    end
endmodule : testbench
`default_nettype wire
